/* rtl/ssx_exec.sv */
`timescale 1ns/100ps
module ssx_exec
  import ssx_pkg::*;
#(
  parameter int PC_W = SSX_PC_W,
  parameter int TABLE_POINTER_W = SSX_TABLE_POINTER_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // instruction request
  input wire ssx_req_t req,
  input wire logic [PC_W-1:0] pc,
  input wire logic [TABLE_POINTER_W-1:0] table_pointer,
  // program memory read port
  output ssx_op_t rom_op_q,
  output logic rom_rd_q,
  output logic [PC_W-1:0] rom_addr_q,
  input wire logic [SSX_ROM_W-1:0] rom_data,
  // results
  output ssx_wr_t mem_wr_q,
  output logic [SSX_DATA_W-1:0] acc_q,
  output logic [SSX_ROM_W-SSX_DATA_W-1:0] table_high_latch_q,
  output ssx_flags_t flags_q,
  // pipeline control
  output logic discard_q,
  output logic busy_q
);
  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  // refuse a table pointer that cannot sit inside the program counter
  if (TABLE_POINTER_W < 1 || TABLE_POINTER_W > PC_W) begin : g_bad_width
    $error("ssx_exec: table pointer width must be 1 to PC_W bits");
  end

  // low pc bits that the table pointer replaces
  localparam logic [PC_W-1:0] OFFS_MASK = PC_W'((1 << TABLE_POINTER_W) - 1);

  typedef enum logic [1:0] {ST_RUN, ST_DUMMY, ST_TABLE} ssx_state_t;

  typedef struct packed {
    ssx_state_t st;
    logic busy;
    logic [SSX_DATA_W-1:0] acc;
    logic [SSX_ROM_W-SSX_DATA_W-1:0] table_high_latch;
    ssx_flags_t flags;
    ssx_wr_t wr;
    logic discard;
    logic rom_rd;
    logic [PC_W-1:0] rom_addr;
    ssx_op_t rom_op;
  } ssx_regs_t;

  ssx_regs_t s_q;
  ssx_regs_t s_d;

  // ---------------------------------------------------------------
  // datapath helpers
  // ---------------------------------------------------------------
  logic [7:0] swapped;
  logic [7:0] xor_mem;
  logic [7:0] xor_imm;
  logic byte_zero;
  logic bit_zero;
  logic [PC_W-1:0] page_base;
  logic [PC_W-1:0] tbl_ext;

  // nibble exchange of the operand
  assign swapped = {req.mem_data[SSX_NIB_LO +: SSX_NIB_W],
                    req.mem_data[SSX_NIB_HI +: SSX_NIB_W]};
  assign xor_mem = s_q.acc ^ req.mem_data;
  assign xor_imm = s_q.acc ^ req.imm;
  assign byte_zero = (req.mem_data == SSX_ZERO_BYTE);
  assign bit_zero = ~req.mem_data[req.bit_sel];
  assign tbl_ext = PC_W'(table_pointer);
  // page base: upper pc bits kept above the table pointer field
  assign page_base = pc & ~OFFS_MASK;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.wr.we = 1'b0;
    s_d.discard = 1'b0;
    s_d.rom_rd = 1'b0;
    case (s_q.st)
      ST_DUMMY: begin
        // dummy cycle replacing the discarded instruction
        s_d.st = ST_RUN;
      end
      ST_TABLE: begin
        // word arrives: low byte to memory, high part to the latch
        s_d.wr.we = 1'b1;
        s_d.wr.data = rom_data[SSX_DATA_W-1:0];
        s_d.table_high_latch = rom_data[SSX_ROM_W-1:SSX_DATA_W];
        s_d.st = ST_RUN;
      end
      ST_RUN: begin
        if (req.valid) begin
          case (req.op)
            SSX_OP_NIBBLE_EXCHANGE: begin
              s_d.wr.we = 1'b1;
              s_d.wr.data = swapped;
            end
            SSX_OP_NIBBLE_EXCHANGE_TO_ACC: begin
              s_d.acc = swapped;
            end
            SSX_OP_SKIP_IF_ZERO: begin
              if (byte_zero) begin
                s_d.discard = 1'b1;
                s_d.st = ST_DUMMY;
              end
            end
            SSX_OP_COPY_THEN_SKIP_IF_ZERO: begin
              s_d.acc = req.mem_data;
              if (byte_zero) begin
                s_d.discard = 1'b1;
                s_d.st = ST_DUMMY;
              end
            end
            SSX_OP_SKIP_IF_BIT_ZERO: begin
              if (bit_zero) begin
                s_d.discard = 1'b1;
                s_d.st = ST_DUMMY;
              end
            end
            SSX_OP_TABLE_READ_CURRENT_PAGE: begin
              s_d.rom_rd = 1'b1;
              s_d.rom_addr = page_base | tbl_ext;
              s_d.rom_op = req.op;
              s_d.st = ST_TABLE;
            end
            SSX_OP_TABLE_READ_LAST_PAGE: begin
              // last page: all upper bits set
              s_d.rom_rd = 1'b1;
              s_d.rom_addr = ~OFFS_MASK | tbl_ext;
              s_d.rom_op = req.op;
              s_d.st = ST_TABLE;
            end
            SSX_OP_XOR_TO_ACC: begin
              s_d.acc = xor_mem;
              s_d.flags.z = (xor_mem == SSX_ZERO_BYTE);
            end
            SSX_OP_EXCLUSIVE_OR_INTO_MEMORY: begin
              s_d.wr.we = 1'b1;
              s_d.wr.data = xor_mem;
              s_d.flags.z = (xor_mem == SSX_ZERO_BYTE);
            end
            SSX_OP_XOR_IMMEDIATE: begin
              s_d.acc = xor_imm;
              s_d.flags.z = (xor_imm == SSX_ZERO_BYTE);
            end
            default: begin
              s_d.st = ST_RUN;
            end
          endcase
        end
      end
      default: begin
        s_d.st = ST_RUN;
      end
    endcase
    // busy flop follows the next state so busy_q needs no decode
    s_d.busy = (s_d.st != ST_RUN);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '{st: ST_RUN, busy: 1'b0, acc: SSX_ACC_RST, table_high_latch: '0, flags: '0, wr: '0,
               discard: 1'b0, rom_rd: 1'b0, rom_addr: '0, rom_op: SSX_OP_NONE};
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign acc_q = s_q.acc;
  assign table_high_latch_q = s_q.table_high_latch;
  assign flags_q = s_q.flags;
  assign mem_wr_q = s_q.wr;
  assign discard_q = s_q.discard;
  assign rom_rd_q = s_q.rom_rd;
  assign rom_addr_q = s_q.rom_addr;
  assign rom_op_q = s_q.rom_op;
  assign busy_q = s_q.busy;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_swap_write;
    @(posedge clk) disable iff (!arst_n)
    (req.valid && s_q.st == ST_RUN && req.op == SSX_OP_NIBBLE_EXCHANGE) |=>
      mem_wr_q.we && mem_wr_q.data == {$past(req.mem_data[3:0]), $past(req.mem_data[7:4])};
  endproperty
  a_swap_write: assert property (p_swap_write) else $error("swap write wrong");

  property p_swap_acc;
    @(posedge clk) disable iff (!arst_n)
    (req.valid && s_q.st == ST_RUN && req.op == SSX_OP_NIBBLE_EXCHANGE_TO_ACC) |=>
      !mem_wr_q.we && acc_q == {$past(req.mem_data[3:0]), $past(req.mem_data[7:4])};
  endproperty
  a_swap_acc: assert property (p_swap_acc) else $error("swap to acc wrong");

  property p_skip_taken;
    @(posedge clk) disable iff (!arst_n)
    (req.valid && s_q.st == ST_RUN && req.op == SSX_OP_SKIP_IF_ZERO && req.mem_data == 8'h00)
      |=> discard_q && busy_q ##1 !busy_q && !discard_q;
  endproperty
  a_skip_taken: assert property (p_skip_taken) else $error("taken skip timing wrong");

  property p_skip_not;
    @(posedge clk) disable iff (!arst_n)
    (req.valid && s_q.st == ST_RUN && req.op == SSX_OP_SKIP_IF_ZERO && req.mem_data != 8'h00)
      |=> !discard_q && !busy_q;
  endproperty
  a_skip_not: assert property (p_skip_not) else $error("untaken skip stalled");

  property p_copy_skip;
    @(posedge clk) disable iff (!arst_n)
    (req.valid && s_q.st == ST_RUN && req.op == SSX_OP_COPY_THEN_SKIP_IF_ZERO) |=>
      acc_q == $past(req.mem_data) && discard_q == ($past(req.mem_data) == 8'h00);
  endproperty
  a_copy_skip: assert property (p_copy_skip) else $error("copy and skip wrong");

  property p_bit_skip;
    @(posedge clk) disable iff (!arst_n)
    (req.valid && s_q.st == ST_RUN && req.op == SSX_OP_SKIP_IF_BIT_ZERO) |=>
      discard_q == !$past(req.mem_data[req.bit_sel]);
  endproperty
  a_bit_skip: assert property (p_bit_skip) else $error("bit skip wrong");

  property p_table;
    @(posedge clk) disable iff (!arst_n)
    rom_rd_q |=> mem_wr_q.we && mem_wr_q.data == $past(rom_data[7:0]) &&
      table_high_latch_q == $past(rom_data[13:8]);
  endproperty
  a_table: assert property (p_table) else $error("table read wrong");

  property p_xor_mem;
    @(posedge clk) disable iff (!arst_n)
    (req.valid && s_q.st == ST_RUN && req.op == SSX_OP_EXCLUSIVE_OR_INTO_MEMORY) |=>
      mem_wr_q.we && mem_wr_q.data == ($past(acc_q) ^ $past(req.mem_data)) &&
      flags_q.z == (mem_wr_q.data == 8'h00) && acc_q == $past(acc_q);
  endproperty
  a_xor_mem: assert property (p_xor_mem) else $error("memory xor wrong");

  property p_xor_acc_flags;
    @(posedge clk) disable iff (!arst_n)
    (req.valid && s_q.st == ST_RUN && (req.op == SSX_OP_XOR_TO_ACC ||
      req.op == SSX_OP_XOR_IMMEDIATE)) |=>
      flags_q.z == (acc_q == 8'h00) && flags_q.c == $past(flags_q.c) &&
      flags_q.ov == $past(flags_q.ov);
  endproperty
  a_xor_acc_flags: assert property (p_xor_acc_flags) else $error("acc xor flags wrong");

  property p_flags_kept;
    @(posedge clk) disable iff (!arst_n)
    (req.valid && s_q.st == ST_RUN && req.op inside {SSX_OP_NIBBLE_EXCHANGE,
      SSX_OP_NIBBLE_EXCHANGE_TO_ACC, SSX_OP_SKIP_IF_ZERO, SSX_OP_COPY_THEN_SKIP_IF_ZERO,
      SSX_OP_SKIP_IF_BIT_ZERO, SSX_OP_TABLE_READ_CURRENT_PAGE, SSX_OP_TABLE_READ_LAST_PAGE})
      |=> $stable(flags_q);
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("flags changed");

  // a request during the dummy or fetch cycle is refused
  property p_busy_refuse;
    @(posedge clk) disable iff (!arst_n)
    busy_q |=> !discard_q && !busy_q && !rom_rd_q && $stable(acc_q) && $stable(flags_q);
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("request taken while busy");

  // current page read keeps the upper pc bits
  property p_tbl_cur;
    @(posedge clk) disable iff (!arst_n)
    (req.valid && s_q.st == ST_RUN && req.op == SSX_OP_TABLE_READ_CURRENT_PAGE) |=>
      rom_rd_q && (rom_addr_q & ~OFFS_MASK) == ($past(pc) & ~OFFS_MASK) &&
      rom_addr_q[TABLE_POINTER_W-1:0] == $past(table_pointer);
  endproperty
  a_tbl_cur: assert property (p_tbl_cur) else $error("current page address wrong");

  // last page read forces every upper bit high
  property p_tbl_last;
    @(posedge clk) disable iff (!arst_n)
    (req.valid && s_q.st == ST_RUN && req.op == SSX_OP_TABLE_READ_LAST_PAGE) |=>
      rom_rd_q && (rom_addr_q | OFFS_MASK) == '1 &&
      rom_addr_q[TABLE_POINTER_W-1:0] == $past(table_pointer);
  endproperty
  a_tbl_last: assert property (p_tbl_last) else $error("last page address wrong");
endmodule

/* rtl/ssx_pkg.sv */
package ssx_pkg;
  // ---------------------------------------------------------------
  // operation selects for this instruction group
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    SSX_OP_NONE,
    SSX_OP_NIBBLE_EXCHANGE,
    SSX_OP_NIBBLE_EXCHANGE_TO_ACC,
    SSX_OP_SKIP_IF_ZERO,
    SSX_OP_COPY_THEN_SKIP_IF_ZERO,
    SSX_OP_SKIP_IF_BIT_ZERO,
    SSX_OP_TABLE_READ_CURRENT_PAGE,
    SSX_OP_TABLE_READ_LAST_PAGE,
    SSX_OP_XOR_TO_ACC,
    SSX_OP_EXCLUSIVE_OR_INTO_MEMORY,
    SSX_OP_XOR_IMMEDIATE
  } ssx_op_t;

  // ---------------------------------------------------------------
  // widths and field positions
  // ---------------------------------------------------------------
  localparam int SSX_DATA_W = 8;
  localparam int SSX_ROM_W = 14;
  localparam int SSX_PC_W = 10;
  localparam int SSX_TABLE_POINTER_W = 8;
  localparam int SSX_BIT_W = 3;
  localparam int SSX_NIB_LO = 0;
  localparam int SSX_NIB_HI = 4;
  localparam int SSX_NIB_W = 4;
  localparam logic [7:0] SSX_ZERO_BYTE = 8'h00;
  localparam logic [7:0] SSX_ACC_RST = 8'h00;

  // ---------------------------------------------------------------
  // one instruction request from the decoder
  // ---------------------------------------------------------------
  typedef struct packed {
    logic valid;
    ssx_op_t op;
    logic [7:0] mem_data;
    logic [2:0] bit_sel;
    logic [7:0] imm;
  } ssx_req_t;

  // memory write-back
  typedef struct packed {
    logic we;
    logic [7:0] data;
  } ssx_wr_t;

  // status flags handled here
  typedef struct packed {
    logic c;
    logic ac;
    logic z;
    logic ov;
    logic pd;
    logic to;
  } ssx_flags_t;
endpackage

/* verification/swap_skip_table_xor_exec_test.sv */
`timescale 1ns/100ps
module swap_skip_table_xor_exec_test
  import ssx_pkg::*;
;
  // ---------------------------------------------------------------
  // clock, reset and design hookup
  // ---------------------------------------------------------------
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  ssx_req_t req = '0;
  logic [9:0] pc = 10'h2c5;
  logic [7:0] table_pointer = 8'h37;
  logic [13:0] rom_data = 14'h0000;
  ssx_op_t rom_op_q;
  logic rom_rd_q;
  logic [9:0] rom_addr_q;
  ssx_wr_t mem_wr_q;
  logic [7:0] acc_q;
  logic [5:0] table_high_latch_q;
  ssx_flags_t flags_q;
  logic discard_q;
  logic busy_q;
  int errors = 0;
  int cmp_count = 0;
  logic [7:0] acc_e = 8'h00;
  logic z_e = 1'b0;

  // 8 ns period
  always #4 clk = ~clk;

  ssx_exec i_ssx_exec (
    .clk(clk), .arst_n(arst_n), .req(req), .pc(pc), .table_pointer(table_pointer),
    .rom_op_q(rom_op_q), .rom_rd_q(rom_rd_q), .rom_addr_q(rom_addr_q), .rom_data(rom_data),
    .mem_wr_q(mem_wr_q), .acc_q(acc_q), .table_high_latch_q(table_high_latch_q),
    .flags_q(flags_q), .discard_q(discard_q), .busy_q(busy_q)
  );

  // ---------------------------------------------------------------
  // shared helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one request taken at the next edge, outputs settled after it
  task automatic go(input ssx_op_t op, input logic [7:0] m, input logic [2:0] b,
                    input logic [7:0] imm);
    @(posedge clk);
    req <= '{valid: 1'b1, op: op, mem_data: m, bit_sel: b, imm: imm};
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
  endtask

  // accumulator and every flag against the tracked values
  task automatic state_chk();
    chk(16'(acc_q), 16'(acc_e));
    chk(16'(flags_q), 16'({2'b00, z_e, 3'b000}));
  endtask

  // skip outcome: taken means discard plus one dummy cycle
  task automatic skip_chk(input logic taken);
    chk(16'({discard_q, busy_q}), 16'({taken, taken}));
    if (taken) begin
      @(posedge clk);
      #1;
      chk(16'({discard_q, busy_q}), 16'h0000);
    end
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_xor();
    // each xor form drives the zero flag both ways
    go(SSX_OP_XOR_IMMEDIATE, 8'hff, 3'h0, 8'h5a);
    acc_e = 8'h5a;
    state_chk();
    go(SSX_OP_XOR_TO_ACC, 8'h5a, 3'h0, 8'h00);
    acc_e = 8'h00;
    z_e = 1'b1;
    chk(16'(mem_wr_q.we), 16'h0000);
    state_chk();
    go(SSX_OP_XOR_IMMEDIATE, 8'h00, 3'h0, 8'h55);
    acc_e = 8'h55;
    z_e = 1'b0;
    chk(16'(mem_wr_q.we), 16'h0000);
    state_chk();
    go(SSX_OP_EXCLUSIVE_OR_INTO_MEMORY, 8'h55, 3'h0, 8'h00);
    z_e = 1'b1;
    chk(16'(mem_wr_q), 16'h0100);
    state_chk();
    go(SSX_OP_XOR_TO_ACC, 8'h0f, 3'h0, 8'h00);
    acc_e = 8'h5a;
    z_e = 1'b0;
    state_chk();
    go(SSX_OP_XOR_IMMEDIATE, 8'h00, 3'h0, 8'h5a);
    acc_e = 8'h00;
    z_e = 1'b1;
    state_chk();
    go(SSX_OP_EXCLUSIVE_OR_INTO_MEMORY, 8'h3c, 3'h0, 8'h00);
    z_e = 1'b0;
    chk(16'(mem_wr_q), 16'h013c);
    state_chk();
    go(SSX_OP_XOR_TO_ACC, 8'h00, 3'h0, 8'h00);
    z_e = 1'b1;
    state_chk();
    $display("test xor done");
  endtask

  task automatic t_swap();
    go(SSX_OP_NIBBLE_EXCHANGE, 8'h3c, 3'h0, 8'h00);
    chk(16'(mem_wr_q), 16'h01c3);
    state_chk();
    go(SSX_OP_NIBBLE_EXCHANGE_TO_ACC, 8'ha5, 3'h0, 8'h00);
    acc_e = 8'h5a;
    chk(16'(mem_wr_q.we), 16'h0000);
    state_chk();
    $display("test swap done");
  endtask

  task automatic t_skip();
    // the request offered in the dummy cycle must be refused
    @(posedge clk);
    req <= '{valid: 1'b1, op: SSX_OP_SKIP_IF_ZERO, mem_data: 8'h00, bit_sel: 3'h0,
             imm: 8'h00};
    @(posedge clk);
    req <= '{valid: 1'b1, op: SSX_OP_XOR_IMMEDIATE, mem_data: 8'h00, bit_sel: 3'h0,
             imm: 8'hff};
    #1;
    chk(16'({discard_q, busy_q}), 16'h0003);
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
    chk(16'({discard_q, busy_q}), 16'h0000);
    state_chk();
    go(SSX_OP_SKIP_IF_ZERO, 8'h01, 3'h0, 8'h00);
    skip_chk(1'b0);
    go(SSX_OP_COPY_THEN_SKIP_IF_ZERO, 8'h00, 3'h0, 8'h00);
    acc_e = 8'h00;
    state_chk();
    skip_chk(1'b1);
    go(SSX_OP_COPY_THEN_SKIP_IF_ZERO, 8'h80, 3'h0, 8'h00);
    acc_e = 8'h80;
    state_chk();
    skip_chk(1'b0);
    $display("test skip done");
  endtask

  task automatic t_bit_skip();
    for (int i = 0; i < 8; i++) begin
      go(SSX_OP_SKIP_IF_BIT_ZERO, ~(8'h01 << i), i[2:0], 8'h00);
      skip_chk(1'b1);
      go(SSX_OP_SKIP_IF_BIT_ZERO, 8'h01 << i, i[2:0], 8'h00);
      skip_chk(1'b0);
    end
    state_chk();
    $display("test bit skip done");
  endtask

  task automatic t_table(input ssx_op_t op, input logic [1:0] page, input logic [13:0] w);
    // program word stands before the read, valid in the fetch cycle
    @(posedge clk);
    rom_data <= w;
    go(op, 8'h00, 3'h0, 8'h00);
    chk(16'({rom_rd_q, busy_q, rom_op_q}), 16'({2'b11, op}));
    chk(16'(rom_addr_q), 16'({page, table_pointer}));
    @(posedge clk);
    #1;
    chk(16'(mem_wr_q), 16'({1'b1, w[7:0]}));
    chk(16'({table_high_latch_q, busy_q}), 16'({w[13:8], 1'b0}));
    state_chk();
    $display("test table read done");
  endtask

  // ---------------------------------------------------------------
  // closing and main sequence
  // ---------------------------------------------------------------
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #20000;
    errors++;
    $display("BAD %0t watchdog expired", $time);
    print_verdict();
  end

  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    chk(16'({busy_q, discard_q, rom_rd_q, mem_wr_q.we}), 16'h0000);
    chk(16'({table_high_latch_q, rom_addr_q}), 16'h0000);
    state_chk();
    t_xor();
    t_swap();
    t_skip();
    t_bit_skip();
    t_table(SSX_OP_TABLE_READ_CURRENT_PAGE, pc[9:8], 14'h2a5c);
    t_table(SSX_OP_TABLE_READ_LAST_PAGE, 2'b11, 14'h15a3);
    print_verdict();
  end
endmodule
